// ---- design/pps_clk_if.sv ----
// Purpose: clock output configuration between control and divider
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ns
interface pps_clk_if;
  logic                 en;
  logic                 in_mode;
  pps_pkg::pps_div_sel_t sel;
  logic                 sync_pulse;
  logic                 clk_out;
  modport ctl (output en, output in_mode, output sel, output sync_pulse, input clk_out);
  modport div (input en, input in_mode, input sel, input sync_pulse, output clk_out);
endinterface

// ---- design/pps_clkdiv.sv ----
// Purpose: power-of-two postscaler for the clock output pin
// Assumes: i_clk stands for the supervisor processor clock
// Notes:   divide by one gates the clock itself, so it may glitch on enable
`timescale 1ns/1ns
`include "pps_defs.svh"
module pps_clkdiv (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // configuration
  pps_clk_if.div    cif
);
  import pps_pkg::*;

  logic [14:0] cnt_ff;
  logic [14:0] nxt_cnt;
  logic        div_ff;

  function automatic logic pps_tap(input logic [14:0] c, input pps_div_sel_t s);
    pps_tap = (s == 4'h0) ? 1'b0 : c[s - 4'h1];
  endfunction

  assign nxt_cnt = 15'(cnt_ff + 15'h1);

  // counter restarts on a sync edge so the output phase follows the input
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= 15'h0;
    end else if (!cif.en || cif.sync_pulse) begin
      cnt_ff <= 15'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 1'b0;
    end else if (!cif.en || cif.in_mode || cif.sync_pulse) begin
      div_ff <= 1'b0;
    end else begin
      div_ff <= pps_tap(nxt_cnt, cif.sel);
    end
  end

  // divide by one takes the processor clock itself, other settings take div_ff
  assign cif.clk_out = (cif.sel == 4'h0) ? (i_clk & cif.en & ~cif.in_mode) : div_ff;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  clk_off_dis_a: assert property (!cif.en |=> !div_ff && cnt_ff == 15'h0)
    else $error("clock divider runs while disabled");
  // three cycles, so the earlier value already comes from divide by two
  div_two_a: assert property ((cif.en && !cif.in_mode && cif.sel == 4'h1
      && !cif.sync_pulse)[*3] |-> div_ff != $past(div_ff))
    else $error("divide by two does not toggle each cycle");
  sync_restart_a: assert property (cif.en && cif.sync_pulse |=> cnt_ff == 15'h0)
    else $error("sync edge did not restart the divider");
  div_cover: cover property (cif.en && !cif.in_mode && cif.sel == 4'h6 && $rose(div_ff));
endmodule

// ---- design/pps_defs.svh ----
// Purpose: constants of the power port switch control block
// Assumes: 50 MHz system clock
// Notes:   included by the divider and top design files only
//
// Overview of operation
// - a high external enable input turns its own power port on
// - an enabled, untripped port drives all four supply pins of that port
// - port enable is commanded state OR external enable input
// - exceeding a port's current limit switches that port off
// - each port's indicator is lit exactly while the port is on
// - power-off input halts the supervisor's command and telemetry logic
// - low supervisor reset input resets the supervisor state
// - clock output carries processor clock through a postscale divider
// - undivided clock output source is the supervisor processor clock
// - clock pin can instead be a synchronisation input to the supervisor
// - clock output is off after reset, configured only by command
// - enabling the clock output leaves all other behaviour unchanged
// - supervisor is an I2C slave working at 100 kHz and 400 kHz
// - slave may stretch SCL low; master waits for its release
// - commands arrive over I2C; reads return timestamped telemetry
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_NPORTS      5
`define PPS_NPINS       4
`define PPS_I2C_ADDR    7'h58
`define PPS_CLK_NS      20
`define PPS_STRETCH_NS  2000
`define PPS_STRETCH_CYC ((`PPS_STRETCH_NS + `PPS_CLK_NS - 1) / `PPS_CLK_NS)
`define PPS_RC_KHZ      15210
`define PPS_CMD_PORT    8'h01
`define PPS_CMD_CLK     8'h02
`define PPS_CFG_EN      7
`define PPS_CFG_IN      6
`define PPS_BITS_BYTE   4'h8
`define PPS_IDX_LAST    2'h3
`define PPS_SYNC_RST    15'h4003
`endif

// ---- design/pps_pkg.sv ----
// Purpose: shared types of the power port switch control block
// Assumes: nothing
// Notes:   i2c states are gray coded along the byte path
package pps_pkg;
  typedef enum logic [2:0] {
    PPS_IDLE = 3'h0,
    PPS_ADDR = 3'h1,
    PPS_AACK = 3'h3,
    PPS_WR   = 3'h2,
    PPS_WACK = 3'h6,
    PPS_RD   = 3'h7,
    PPS_RACK = 3'h5
  } pps_i2c_st_t;
  typedef logic [3:0] pps_div_sel_t;
  typedef logic [4:0] pps_port_t;
endpackage

// ---- design/pps_top.sv ----
// Purpose: power port switching, trip latches, i2c command slave, clock pin
// Assumes: all pin inputs are asynchronous to I_CLK
// Notes:   I_CLK stands in for the supervisor processor clock
`timescale 1ns/1ns
`include "pps_defs.svh"
module pps_top (
  // clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  // supervisor control pins
  input  wire logic              I_RESET_N,
  input  wire logic              I_OFF_VCC,
  output logic                   O_SUPERVISOR_ACTIVE,
  // power ports
  input  wire logic              I_EXTERNAL_PORT_ENABLE_ONE,
  input  wire logic              I_EXTERNAL_PORT_ENABLE_TWO,
  input  wire logic              I_EXTERNAL_PORT_ENABLE_THREE,
  input  wire logic              I_EXTERNAL_PORT_ENABLE_FOUR,
  input  wire logic              I_EXTERNAL_PORT_ENABLE_FIVE,
  input  wire pps_pkg::pps_port_t I_PORT_OVERCURRENT,
  output logic [19:0]            O_SWITCHED_BATTERY_SUPPLY,
  output pps_pkg::pps_port_t     O_PORT_LED,
  // i2c slave pins
  input  wire logic              I_SCL,
  output logic                   O_SCL,
  output logic                   O_SCL_OE_N,
  input  wire logic              I_SDA,
  output logic                   O_SDA,
  output logic                   O_SDA_OE_N,
  // clock pin
  input  wire logic              I_CLK_PIN,
  output logic                   O_CLK_PIN,
  output logic                   O_CLK_PIN_OE_N
);
  import pps_pkg::*;

  logic [14:0]  s1_ff;
  logic [14:0]  s2_ff;
  logic [14:0]  pin_raw;
  logic         rst_n_s, off_s, scl_s, sda_s, ckp_s;
  pps_port_t    ext_s, oc_s;
  logic         scl_prev_ff, sda_prev_ff, ckp_prev_ff;
  logic         scl_rise, scl_fall, start, stop, ev_ok, sup_clr;
  pps_port_t    cmd_ff, trip_ff, pwr_ff, en_prev_ff;
  pps_port_t    en_eff, en_rise, nxt_trip;
  pps_i2c_st_t  st_ff;
  logic [3:0]   bit_ff;
  logic [7:0]   sh_ff;
  logic [7:0]   op_ff;
  logic         rw_ff, ack_ok_ff, sda_lo_ff;
  logic [1:0]   idx_ff;
  logic [6:0]   str_ff;
  logic [23:0]  ts_ff;
  logic [23:0]  snap_ff;
  logic [7:0]   tlm_byte;
  logic         addr_hit, wr_done, rd_load;
  logic         ck_en_ff, ck_in_ff;
  pps_div_sel_t ck_sel_ff;

  pps_clk_if cif ();

  function automatic logic [7:0] pps_tlm(input logic [1:0] i, input logic [23:0] t,
                                         input pps_port_t p);
    unique case (i)
      2'h0: pps_tlm = t[23:16];
      2'h1: pps_tlm = t[15:8];
      2'h2: pps_tlm = t[7:0];
      2'h3: pps_tlm = {3'h0, p};
    endcase
  endfunction

  function automatic logic [19:0] pps_expand(input pps_port_t p);
    for (int k = 0; k < `PPS_NPORTS; k++) begin
      pps_expand[k*`PPS_NPINS +: `PPS_NPINS] = {`PPS_NPINS{p[k]}};
    end
  endfunction

  // read byte is picked before the load so its msb leaves with it
  assign tlm_byte = pps_tlm(idx_ff, snap_ff, pwr_ff);

  // two stage synchroniser for every pin input
  assign pin_raw = {I_RESET_N, I_OFF_VCC, I_EXTERNAL_PORT_ENABLE_FIVE,
                    I_EXTERNAL_PORT_ENABLE_FOUR, I_EXTERNAL_PORT_ENABLE_THREE,
                    I_EXTERNAL_PORT_ENABLE_TWO, I_EXTERNAL_PORT_ENABLE_ONE,
                    I_PORT_OVERCURRENT, I_CLK_PIN, I_SCL, I_SDA};
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      s1_ff <= `PPS_SYNC_RST;
      s2_ff <= `PPS_SYNC_RST;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
    end
  end
  assign {rst_n_s, off_s, ext_s, oc_s, ckp_s, scl_s, sda_s} = s2_ff;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      ckp_prev_ff <= 1'b0;
    end else begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      ckp_prev_ff <= ckp_s;
    end
  end

  assign sup_clr  = ~rst_n_s | off_s;
  assign scl_rise = scl_s & ~scl_prev_ff;
  assign scl_fall = ~scl_s & scl_prev_ff;
  assign start    = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop     = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign ev_ok    = ~sup_clr & ~start & ~stop;

  // port enable and trip latch; a trip in the same cycle as an enable edge wins
  assign en_eff   = cmd_ff | ext_s;
  assign en_rise  = en_eff & ~en_prev_ff;
  assign nxt_trip = (trip_ff & ~en_rise) | (oc_s & en_eff);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      en_prev_ff <= 5'h0;
      trip_ff    <= 5'h0;
      pwr_ff     <= 5'h0;
    end else begin
      en_prev_ff <= en_eff;
      trip_ff    <= nxt_trip;
      pwr_ff     <= en_eff & ~nxt_trip;
    end
  end
  assign O_SWITCHED_BATTERY_SUPPLY = pps_expand(pwr_ff);
  assign O_PORT_LED                = pwr_ff;
  assign O_SUPERVISOR_ACTIVE       = ~sup_clr;

  // i2c byte engine
  assign addr_hit = sh_ff[7:1] == `PPS_I2C_ADDR;
  assign wr_done  = ev_ok & scl_fall & (st_ff == PPS_WR) & (bit_ff == `PPS_BITS_BYTE);
  assign rd_load  = ev_ok & scl_fall & (((st_ff == PPS_AACK) & rw_ff)
                  | ((st_ff == PPS_RACK) & ack_ok_ff));

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_ff     <= PPS_IDLE;
      bit_ff    <= 4'h0;
      sh_ff     <= 8'h0;
      rw_ff     <= 1'b0;
      ack_ok_ff <= 1'b0;
      sda_lo_ff <= 1'b0;
      idx_ff    <= 2'h0;
    end else if (sup_clr || stop) begin
      st_ff     <= PPS_IDLE;
      sda_lo_ff <= 1'b0;
    end else if (start) begin
      st_ff     <= PPS_ADDR;
      bit_ff    <= 4'h0;
      idx_ff    <= 2'h0;
      sda_lo_ff <= 1'b0;
    end else if (scl_rise) begin
      if (st_ff == PPS_ADDR || st_ff == PPS_WR) begin
        sh_ff  <= {sh_ff[6:0], sda_s};
        bit_ff <= 4'(bit_ff + 4'h1);
      end
      if (st_ff == PPS_RACK) begin
        ack_ok_ff <= ~sda_s;
      end
    end else if (rd_load) begin
      st_ff     <= PPS_RD;
      sh_ff     <= tlm_byte;
      sda_lo_ff <= ~tlm_byte[7];
      bit_ff    <= 4'h1;
      idx_ff    <= (idx_ff == `PPS_IDX_LAST) ? idx_ff : 2'(idx_ff + 2'h1);
    end else if (scl_fall) begin
      unique case (st_ff)
        PPS_IDLE: begin
        end
        PPS_ADDR: begin
          if (bit_ff == `PPS_BITS_BYTE) begin
            st_ff     <= addr_hit ? PPS_AACK : PPS_IDLE;
            sda_lo_ff <= addr_hit;
            rw_ff     <= sh_ff[0];
            bit_ff    <= 4'h0;
          end
        end
        PPS_AACK, PPS_WACK: begin
          st_ff     <= PPS_WR;
          sda_lo_ff <= 1'b0;
        end
        PPS_WR: begin
          if (bit_ff == `PPS_BITS_BYTE) begin
            st_ff     <= PPS_WACK;
            sda_lo_ff <= 1'b1;
            bit_ff    <= 4'h0;
            idx_ff    <= (idx_ff == `PPS_IDX_LAST) ? idx_ff : 2'(idx_ff + 2'h1);
          end
        end
        PPS_RD: begin
          if (bit_ff == `PPS_BITS_BYTE) begin
            st_ff     <= PPS_RACK;
            sda_lo_ff <= 1'b0;
            bit_ff    <= 4'h0;
          end else begin
            sda_lo_ff <= ~sh_ff[6];
            sh_ff     <= {sh_ff[6:0], 1'b0};
            bit_ff    <= 4'(bit_ff + 4'h1);
          end
        end
        PPS_RACK: begin
          st_ff <= PPS_IDLE;
        end
        default: begin
          st_ff <= PPS_IDLE;
        end
      endcase
    end
  end

  // stretch after each address and write ack so command handling never overruns
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      str_ff <= 7'h0;
    end else if (sup_clr) begin
      str_ff <= 7'h0;
    end else if (ev_ok && scl_fall && (st_ff == PPS_AACK || st_ff == PPS_WACK)) begin
      str_ff <= 7'(`PPS_STRETCH_CYC);
    end else if (str_ff != 7'h0) begin
      str_ff <= 7'(str_ff - 7'h1);
    end
  end

  // timestamp and snapshot, taken whenever the own address is matched, read or write
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ts_ff   <= 24'h0;
      snap_ff <= 24'h0;
    end else begin
      ts_ff <= 24'(ts_ff + 24'h1);
      if (ev_ok && scl_fall && st_ff == PPS_ADDR && bit_ff == `PPS_BITS_BYTE && addr_hit) begin
        snap_ff <= ts_ff;
      end
    end
  end

  // command decode: first byte is the opcode, second the argument
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      op_ff     <= 8'h0;
      cmd_ff    <= 5'h0;
      ck_en_ff  <= 1'b0;
      ck_in_ff  <= 1'b0;
      ck_sel_ff <= 4'h0;
    end else if (sup_clr) begin
      cmd_ff    <= 5'h0;
      ck_en_ff  <= 1'b0;
      ck_in_ff  <= 1'b0;
      ck_sel_ff <= 4'h0;
    end else if (wr_done && idx_ff == 2'h0) begin
      op_ff <= sh_ff;
    end else if (wr_done && idx_ff == 2'h1 && op_ff == `PPS_CMD_PORT) begin
      cmd_ff <= sh_ff[4:0];
    end else if (wr_done && idx_ff == 2'h1 && op_ff == `PPS_CMD_CLK) begin
      ck_en_ff  <= sh_ff[`PPS_CFG_EN];
      ck_in_ff  <= sh_ff[`PPS_CFG_IN];
      ck_sel_ff <= sh_ff[3:0];
    end
  end

  assign cif.en         = ck_en_ff;
  assign cif.in_mode    = ck_in_ff;
  assign cif.sel        = ck_sel_ff;
  assign cif.sync_pulse = ck_en_ff & ck_in_ff & ckp_s & ~ckp_prev_ff;

  pps_clkdiv u_div (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .cif   (cif)
  );

  assign O_CLK_PIN      = cif.clk_out;
  assign O_CLK_PIN_OE_N = ~(ck_en_ff & ~ck_in_ff);
  assign O_SCL          = 1'b0;
  assign O_SCL_OE_N     = (str_ff == 7'h0);
  assign O_SDA          = 1'b0;
  assign O_SDA_OE_N     = ~sda_lo_ff;

  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  ext_on_a: assert property ((ext_s & ~oc_s & ~trip_ff) != 5'h0 |=>
      (pwr_ff & $past(ext_s & ~oc_s & ~trip_ff)) == $past(ext_s & ~oc_s & ~trip_ff))
    else $error("external enable did not switch its port on");
  pins_led_a: assert property (O_SWITCHED_BATTERY_SUPPLY[3:0] == {4{O_PORT_LED[0]}}
      && O_SWITCHED_BATTERY_SUPPLY[19:16] == {4{O_PORT_LED[4]}})
    else $error("supply pins disagree with port state");
  or_off_a: assert property ((cmd_ff | ext_s) == 5'h0 |=> O_PORT_LED == 5'h0)
    else $error("port on without any enable source");
  trip_off_a: assert property ((oc_s & en_eff) != 5'h0 |=>
      (pwr_ff & $past(oc_s & en_eff)) == 5'h0)
    else $error("overcurrent port stays powered");
  trip_hold_a: assert property ((trip_ff & ~en_rise) != 5'h0 |=>
      (pwr_ff & $past(trip_ff & ~en_rise)) == 5'h0)
    else $error("tripped port came back without a new enable");
  off_halt_a: assert property (off_s |=> cmd_ff == 5'h0 && st_ff == PPS_IDLE
      && O_SDA_OE_N)
    else $error("supervisor active while powered off");
  rst_clear_a: assert property (!rst_n_s |=> !ck_en_ff && cmd_ff == 5'h0)
    else $error("supervisor reset left state behind");
  addr_ack_a: assert property (ev_ok && scl_fall && st_ff == PPS_ADDR
      && bit_ff == `PPS_BITS_BYTE && addr_hit |=> !O_SDA_OE_N && st_ff == PPS_AACK)
    else $error("own address not acknowledged");
  stretch_len_a: assert property ($rose(!O_SCL_OE_N) |-> (!O_SCL_OE_N)[*8])
    else $error("clock stretch too short");
  port_cmd_a: assert property (wr_done && idx_ff == 2'h1 && op_ff == `PPS_CMD_PORT
      |=> cmd_ff == $past(sh_ff[4:0]))
    else $error("port command not applied");

  trip_cover: cover property ((oc_s & en_eff) != 5'h0 ##[1:20] en_rise != 5'h0);
  read_cover: cover property (st_ff == PPS_RD ##[1:400] st_ff == PPS_RACK);
  clk_cover:  cover property ($rose(ck_en_ff));
endmodule

// ---- verification/pps_host_model.sv ----
// Purpose: host i2c master model facing the port switch block
// Assumes: the bench resolves scl and sda with pull-ups
// Notes:   bit time near 128 cycles, about 390 kHz
`timescale 1ns/1ns
module pps_host_model (
  // clock
  input  wire logic i_clk,
  // bus levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // open-drain drives, low pulls the line
  output logic      o_scl_oe_n,
  output logic      o_sda_oe_n
);
  // third of a bit in clocks: 42 gives about 390 kHz, 166 about 100 kHz
  int qtr = 42;
  int stretch_max = 0;
  initial begin
    o_scl_oe_n = 1'b1;
    o_sda_oe_n = 1'b1;
  end
  task automatic qwait();
    repeat (qtr) @(negedge i_clk);
  endtask
  // slave may hold scl low; bounded so a stuck line cannot hang us
  task automatic scl_rel();
    int n = 0;
    o_scl_oe_n = 1'b1;
    @(negedge i_clk);
    while (i_scl !== 1'b1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    if (n > stretch_max) stretch_max = n;
  endtask
  // sda only moves a third of a bit after scl fell, never while high
  task automatic bit_io(input logic b, output logic r);
    qwait();
    o_sda_oe_n = b;
    qwait();
    scl_rel();
    qwait();
    r = i_sda;
    o_scl_oe_n = 1'b0;
  endtask
  task automatic start();
    o_sda_oe_n = 1'b1;
    scl_rel();
    qwait();
    o_sda_oe_n = 1'b0;
    qwait();
    o_scl_oe_n = 1'b0;
  endtask
  task automatic stop();
    qwait();
    o_sda_oe_n = 1'b0;
    qwait();
    scl_rel();
    qwait();
    o_sda_oe_n = 1'b1;
    qwait();
  endtask
  // msb first, ninth bit is the acknowledge
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack_out);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, r);
    ack_out = ~r;
  endtask
endmodule

// ---- verification/tb_power_port_switch_control.sv ----
// Purpose: self-checking bench of the power port switch control block
// Assumes: 50 MHz clock, inputs change on the falling edge
// Notes:   expected port state kept as integers cmd and trip
`timescale 1ns/1ns
module tb_power_port_switch_control;
  import pps_pkg::*;
  logic             clk, rst, reset_n, off_vcc, clk_pin_drv, ok;
  logic [4:0]       ext, oc;
  logic [19:0]      supply;
  pps_port_t        led;
  logic             active, scl_o, scl_oe_n, sda_o, sda_oe_n, pin_o, pin_oe_n;
  logic             m_scl_oe_n, m_sda_oe_n;
  logic [23:0]      ts1, ts2;
  logic [7:0]       st, lf;
  int               errors, cmp_count, cmd, trip, c;
  wire              scl = m_scl_oe_n & scl_oe_n;
  wire              sda = m_sda_oe_n & sda_oe_n;
  wire              pin = pin_oe_n ? clk_pin_drv : pin_o;

  pps_top uut (.I_CLK(clk), .I_RST(rst), .I_RESET_N(reset_n), .I_OFF_VCC(off_vcc),
    .O_SUPERVISOR_ACTIVE(active), .I_EXTERNAL_PORT_ENABLE_ONE(ext[0]),
    .I_EXTERNAL_PORT_ENABLE_TWO(ext[1]), .I_EXTERNAL_PORT_ENABLE_THREE(ext[2]),
    .I_EXTERNAL_PORT_ENABLE_FOUR(ext[3]), .I_EXTERNAL_PORT_ENABLE_FIVE(ext[4]),
    .I_PORT_OVERCURRENT(oc), .O_SWITCHED_BATTERY_SUPPLY(supply), .O_PORT_LED(led),
    .I_SCL(scl), .O_SCL(scl_o), .O_SCL_OE_N(scl_oe_n), .I_SDA(sda), .O_SDA(sda_o),
    .O_SDA_OE_N(sda_oe_n), .I_CLK_PIN(pin), .O_CLK_PIN(pin_o), .O_CLK_PIN_OE_N(pin_oe_n));
  pps_host_model hm (.i_clk(clk), .i_scl(scl), .i_sda(sda),
    .o_scl_oe_n(m_scl_oe_n), .o_sda_oe_n(m_sda_oe_n));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [19:0] spread(input logic [4:0] m);
    for (int k = 0; k < 5; k++) spread[4*k +: 4] = {4{m[k]}};
  endfunction
  function automatic logic [4:0] powered();
    return (ext | cmd[4:0]) & ~trip[4:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // three edges of pin latency, one spare
  task automatic ports_chk();
    logic [4:0] e;
    e = powered();
    repeat (4) @(negedge clk);
    check(supply, spread(e));
    check(led, e);
  endtask
  task automatic cmd_wr(input logic [7:0] a, input logic [7:0] op, input logic [7:0] arg);
    logic [7:0] q;
    logic       k;
    hm.start();
    hm.xfer(a, 1'b1, q, ok);
    if (ok) begin
      hm.xfer(op, 1'b1, q, k);
      hm.xfer(arg, 1'b1, q, k);
    end
    hm.stop();
  endtask
  task automatic tele(output logic [23:0] ts, output logic [7:0] s);
    logic [7:0] q;
    logic       k;
    hm.start();
    hm.xfer(8'hb1, 1'b1, q, k);
    check(k, 1'b1);
    for (int i = 0; i < 4; i++) begin
      hm.xfer(8'hff, i == 3, q, k);
      if (i < 3) ts = {ts[15:0], q};
      else s = q;
    end
    hm.stop();
  endtask
  task automatic clk_rise(output int n);
    logic pv;
    n = 0;
    do begin
      pv = pin_o;
      @(negedge clk);
      n++;
    end while (!(pv === 1'b0 && pin_o === 1'b1) && n < 5000);
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // whole run is near 53k cycles; give up at 90k
  initial begin
    #1800000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    rst = 1'b1; reset_n = 1'b1; off_vcc = 1'b0; ext = 5'h00; oc = 5'h00;
    clk_pin_drv = 1'b0; errors = 0; cmp_count = 0; cmd = 0; trip = 0; lf = 8'h49;
    repeat (12) @(negedge clk);
    check({supply, led, pin_oe_n, scl_oe_n, sda_oe_n}, {25'h0, 3'h7});
    check({scl_o, sda_o, pin_o}, 3'h0);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(active, 1'b1);
    done("reset");
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      ext = lf[4:0];
      ports_chk();
    end
    done("external");
    ext = 5'h03;
    cmd_wr(8'hb0, 8'h01, 8'h14);
    cmd = 'h14;
    check(ok, 1'b1);
    ports_chk();
    done("command");
    oc = 5'h01;
    trip = 1;
    ports_chk();
    oc = 5'h00;
    ports_chk(); // trip must hold with the cause gone
    ext = 5'h02;
    repeat (4) @(negedge clk);
    ext = 5'h03;
    trip = 0;
    ports_chk();
    done("trip");
    cmd_wr(8'hb0, 8'h02, 8'hc3);
    // toggle the pin so the divider sees sync edges
    for (int i = 0; i < 8; i++) begin
      repeat (4) @(negedge clk);
      clk_pin_drv = ~clk_pin_drv;
    end
    repeat (4) @(negedge clk);
    check(pin_oe_n, 1'b1);
    check(pin_o, 1'b0);
    done("sync input");
    for (int n = 1; n < 8; n += 3) begin
      cmd_wr(8'hb0, 8'h02, {4'h8, n[3:0]});
      check(pin_oe_n, 1'b0);
      clk_rise(c);
      clk_rise(c);
      check(c, 1 << n);
    end
    // divide by one passes the clock itself, so look inside each half period
    cmd_wr(8'hb0, 8'h02, 8'h80);
    @(posedge clk);
    #1;
    check(pin_o, 1'b1);
    #10;
    check(pin_o, 1'b0);
    @(negedge clk);
    hm.qtr = 166;
    cmd_wr(8'hb0, 8'h01, 8'h08);
    hm.qtr = 42;
    check(ok, 1'b1);
    cmd = 'h08;
    ports_chk();
    check(hm.stretch_max > 0, 1'b1);
    done("clock out");
    tele(ts1, st);
    check(st, {3'h0, powered()});
    tele(ts2, st);
    check(ts2 > ts1, 1'b1);
    cmd_wr(8'hb2, 8'h01, 8'h1f);
    check(ok, 1'b0);
    done("telemetry");
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    check(active, 1'b0);
    reset_n = 1'b1;
    cmd = 0;
    ports_chk();
    check(pin_oe_n, 1'b1);
    off_vcc = 1'b1;
    repeat (4) @(negedge clk);
    check(active, 1'b0);
    cmd_wr(8'hb0, 8'h01, 8'h1f);
    check(ok, 1'b0);
    off_vcc = 1'b0;
    repeat (4) @(negedge clk);
    check(active, 1'b1);
    ports_chk();
    done("supervisor");
    conclude();
  end
endmodule
